// File: rtl/madc_pkg.sv
package madc_pkg;
	// ----------------------------------------
	// Timing, in ns, derived cycle counts, widths and reset values
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_SAMPLE_MIN_NS = 150;
	localparam int T_CONV_MODE1_NS = 360;
	localparam int T_CONV_MODE2_NS = 470;
	localparam int T_DATA_VALID_NS = 20;
	localparam int T_MUX_SETUP_NS = 75;
	localparam int T_MUX_HOLD_NS = 40;
	localparam int T_BUS_REL_NS = 60;
	localparam int T_RECOVER_NS = 50;
	localparam int T_TIMEOUT_NS = 2000;
	localparam int SAMPLE_CYC = (T_SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VALID_CYC = (T_DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int SETUP_CYC = (T_MUX_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_MUX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_CYC = (T_BUS_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMEOUT_CYC = T_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 12;
	localparam int DATA_W = 10;
	localparam int SEL_W = 2;
	localparam logic [SEL_W-1:0] SEL_RESET = 2'h0;
	localparam logic [DATA_W-1:0] DATA_RESET = 10'h000;

	typedef enum logic {
		MADC_MODE_SH,
		MADC_MODE_RD
	} madc_mode_t;
endpackage

// File: rtl/madc_timer_if.sv
`timescale 1ns/1ns
interface madc_timer_if;
	logic load;
	logic [madc_pkg::CNT_W-1:0] count;
	logic done;
	modport ctrl (output load, output count, input done);
	modport tmr (input load, input count, output done);
endinterface

// File: rtl/madc_timer.sv
`timescale 1ns/1ns
module madc_timer (
	input wire logic sys_clk,
	input wire logic rstn,
	madc_timer_if.tmr tif
);
	logic [madc_pkg::CNT_W-1:0] cnt_r;
	logic [madc_pkg::CNT_W-1:0] cnt_nxt;
	localparam logic [madc_pkg::CNT_W-1:0] ONE = 12'h001;
	localparam logic [madc_pkg::CNT_W-1:0] ZERO = 12'h000;

	assign cnt_nxt = tif.load ? tif.count : ((cnt_r != ZERO) ? cnt_r - ONE : ZERO);
	// Done from the count alone: load depends on done, so no loop back
	assign tif.done = (cnt_r == ONE);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= ZERO;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// File: rtl/madc_host.sv
`timescale 1ns/1ns
module madc_host #(
	parameter int FOUR_INPUT = 1,
	parameter int TIMEOUT = madc_pkg::TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic mode,
	input wire logic [madc_pkg::SEL_W-1:0] channel,
	output logic busy,
	output logic result_valid,
	output logic [madc_pkg::DATA_W-1:0] result,
	output logic result_timeout,
	output logic cs_n,
	output logic sh_n,
	output logic rd_n,
	output logic chan_sel_lo,
	output logic chan_sel_hi,
	input wire logic int_n,
	input wire logic [madc_pkg::DATA_W-1:0] adc_data
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (FOUR_INPUT != 0 && FOUR_INPUT != 1) begin : g_four_chk
		$error("FOUR_INPUT must be 0 or 1");
	end
	if (TIMEOUT < 1 || TIMEOUT >= (1 << madc_pkg::CNT_W)) begin : g_tmo_chk
		$error("TIMEOUT out of counter range");
	end

	typedef enum logic [3:0] {
		IDLE, SETUP, SAMPLE, CONV, RD_LOW, RD_VALID, RELEASE, RECOVER
	} madc_state_t;

	madc_state_t state_r, state_nxt;
	logic mode_r;
	logic [madc_pkg::SEL_W-1:0] sel_r;
	logic cs_n_r, sh_n_r, rd_n_r;
	logic [madc_pkg::DATA_W-1:0] result_r;
	logic valid_r, timeout_r;
	logic [madc_pkg::CNT_W-1:0] wd_r;
	logic int_n_s1_r, int_n_s2_r;
	logic [madc_pkg::DATA_W-1:0] data_s1_r, data_s2_r;
	logic int_low, wd_expired, capture;
	logic cs_nxt, sh_nxt, rd_nxt;

	localparam logic [madc_pkg::CNT_W-1:0] WD_ONE = 12'h001;
	localparam logic [madc_pkg::CNT_W-1:0] WD_ZERO = 12'h000;

	madc_timer_if tif ();
	madc_timer u_timer (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tif(tif)
	);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			int_n_s1_r <= 1'b1;
			int_n_s2_r <= 1'b1;
			data_s1_r <= madc_pkg::DATA_RESET;
			data_s2_r <= madc_pkg::DATA_RESET;
		end else begin
			int_n_s1_r <= int_n;
			int_n_s2_r <= int_n_s1_r;
			data_s1_r <= adc_data;
			data_s2_r <= data_s1_r;
		end
	end

	assign int_low = !int_n_s2_r;
	assign wd_expired = (wd_r == WD_ONE);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		tif.load = 1'b0;
		tif.count = '0;
		case (state_r)
			IDLE: begin
				if (start) begin
					state_nxt = SETUP;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'(madc_pkg::SETUP_CYC);
				end
			end
			SETUP: begin
				if (tif.done) begin
					state_nxt = (mode_r == madc_pkg::MADC_MODE_RD) ? CONV : SAMPLE;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'((mode_r == madc_pkg::MADC_MODE_RD) ?
						madc_pkg::HOLD_CYC : madc_pkg::SAMPLE_CYC);
				end
			end
			SAMPLE: begin
				if (tif.done) begin
					state_nxt = CONV;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'(madc_pkg::HOLD_CYC);
				end
			end
			CONV: begin
				if (int_low) begin
					if (mode_r == madc_pkg::MADC_MODE_RD) begin
						state_nxt = RD_VALID;
						tif.load = 1'b1;
						tif.count = madc_pkg::CNT_W'(madc_pkg::VALID_CYC);
					end else begin
						state_nxt = RD_LOW;
						tif.load = 1'b1;
						tif.count = madc_pkg::CNT_W'(madc_pkg::VALID_CYC);
					end
				end else if (wd_expired) begin
					state_nxt = RELEASE;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'(madc_pkg::REL_CYC);
				end
			end
			RD_LOW: begin
				if (tif.done) begin
					state_nxt = RD_VALID;
				end
			end
			RD_VALID: begin
				if (mode_r == madc_pkg::MADC_MODE_SH || tif.done) begin
					state_nxt = RELEASE;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'(madc_pkg::REL_CYC);
				end
			end
			RELEASE: begin
				if (tif.done) begin
					state_nxt = RECOVER;
					tif.load = 1'b1;
					tif.count = madc_pkg::CNT_W'(madc_pkg::RECOVER_CYC);
				end
			end
			RECOVER: begin
				if (tif.done && !int_low) begin
					state_nxt = IDLE;
				end
			end
			default: begin
				state_nxt = IDLE;
			end
		endcase
	end

	assign cs_nxt = (state_nxt == IDLE) || (state_nxt == RECOVER);
	assign sh_nxt = !((state_nxt == SAMPLE) ||
		(mode_r == madc_pkg::MADC_MODE_RD && (state_nxt == CONV || state_nxt == RD_VALID)));
	assign rd_nxt = !((state_nxt == RD_LOW) || (state_nxt == RD_VALID) ||
		(mode_r == madc_pkg::MADC_MODE_RD && state_nxt == CONV));
	// device drives valid data on bus only in read
	assign capture = (state_r == RD_VALID) && (state_nxt == RELEASE) && !wd_expired;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= IDLE;
			cs_n_r <= 1'b1;
			sh_n_r <= 1'b1;
			rd_n_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cs_n_r <= cs_nxt;
			sh_n_r <= sh_nxt;
			rd_n_r <= rd_nxt;
		end
	end

	// ----------------------------------------
	// Request latch, watchdog, result
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mode_r <= madc_pkg::MADC_MODE_SH;
			sel_r <= madc_pkg::SEL_RESET;
		end else if (state_r == IDLE && start) begin
			mode_r <= mode;
			sel_r <= (FOUR_INPUT != 0) ? channel : {1'b0, channel[0]};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wd_r <= WD_ZERO;
		end else if (state_r != CONV) begin
			wd_r <= madc_pkg::CNT_W'(TIMEOUT);
		end else if (wd_r != WD_ZERO) begin
			wd_r <= wd_r - WD_ONE;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			result_r <= madc_pkg::DATA_RESET;
			valid_r <= 1'b0;
			timeout_r <= 1'b0;
		end else begin
			valid_r <= capture;
			timeout_r <= (state_r == CONV) && !int_low && wd_expired;
			if (capture) begin
				result_r <= data_s2_r;
			end
		end
	end

	assign busy = (state_r != IDLE);
	assign result_valid = valid_r;
	assign result_timeout = timeout_r;
	assign result = result_r;
	assign cs_n = cs_n_r;
	assign sh_n = sh_n_r;
	assign rd_n = rd_n_r;
	assign chan_sel_lo = sel_r[0];
	assign chan_sel_hi = sel_r[1];
endmodule

// File: testbench/madc_host_sva.sv
`timescale 1ns/1ns
module madc_host_sva #(
	parameter int FOUR_INPUT = 1,
	parameter int TIMEOUT = 200
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic busy,
	input wire logic result_valid,
	input wire logic [madc_pkg::DATA_W-1:0] result,
	input wire logic result_timeout,
	input wire logic cs_n,
	input wire logic sh_n,
	input wire logic rd_n,
	input wire logic chan_sel_lo,
	input wire logic chan_sel_hi,
	input wire logic int_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// ----------
	// Pin rules
	// ----------
	logic [7:0] lo_cnt_r;
	logic [9:0] busy_cnt_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lo_cnt_r <= 8'h00;
			busy_cnt_r <= 10'h000;
		end else begin
			lo_cnt_r <= sh_n ? 8'h00 : lo_cnt_r + 8'h01;
			busy_cnt_r <= busy ? busy_cnt_r + 10'h001 : 10'h000;
		end
	end
	sequence s_read_end;
		##[0:2] (result_valid || result_timeout);
	endsequence
	sel_hold_a: assert property (!cs_n && !$past(cs_n) |-> $stable({chan_sel_hi, chan_sel_lo}))
		else $error("select moved in frame");
	sh_gate_a: assert property (!sh_n |-> !cs_n)
		else $error("sample without select");
	rd_gate_a: assert property (!rd_n |-> !cs_n)
		else $error("read without select");
	sample_width_a: assert property ($rose(sh_n) && rd_n |-> lo_cnt_r >= madc_pkg::SAMPLE_CYC)
		else $error("sample pulse short");
	tied_fall_a: assert property ($fell(sh_n) |-> rd_n || $fell(rd_n))
		else $error("strobes not tied on fall");
	tied_rise_a: assert property ($rose(rd_n) && !$past(sh_n) |-> $rose(sh_n))
		else $error("strobes not tied on rise");
	read_end_a: assert property ($rose(rd_n) |-> s_read_end)
		else $error("read ended without result");
	result_hold_a: assert property ($changed(result) |-> result_valid)
		else $error("result moved without pulse");
	read_after_done_a: assert property ($fell(rd_n) && sh_n |-> !$past(int_n))
		else $error("read before done");
	busy_bound_a: assert property (busy |-> busy_cnt_r < TIMEOUT + 64)
		else $error("transaction too long");
endmodule
bind madc_host madc_host_sva #(.FOUR_INPUT(FOUR_INPUT), .TIMEOUT(TIMEOUT)) sva_i (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.start(start),
	.busy(busy),
	.result_valid(result_valid),
	.result(result),
	.result_timeout(result_timeout),
	.cs_n(cs_n),
	.sh_n(sh_n),
	.rd_n(rd_n),
	.chan_sel_lo(chan_sel_lo),
	.chan_sel_hi(chan_sel_hi),
	.int_n(int_n)
);

// File: testbench/madc_adc_model.sv
`timescale 1ns/1ns
module madc_adc_model (
	input wire logic cs_n,
	input wire logic sh_n,
	input wire logic rd_n,
	input wire logic chan_sel_lo,
	input wire logic chan_sel_hi,
	input wire logic mute,
	output logic int_n,
	output logic [9:0] adc_data
);
	logic [1:0] sel_r;
	logic [9:0] res_r = 10'h000;
	logic [9:0] out_r = 10'h000;
	logic md2_r = 1'b0;
	initial int_n = 1'b1;
	assign adc_data = (!cs_n && !rd_n) ? out_r : ~out_r;
	task automatic conv(input int t);
		#t;
		if (!mute) begin
			res_r = {sel_r, res_r[7:0] + 8'h01};
			// Lands on a clock edge: settle after the host flops sample
			int_n <= 1'b0;
			#20 out_r <= res_r;
		end
	endtask
	always @(negedge sh_n) if (!cs_n) begin
		sel_r = {chan_sel_hi, chan_sel_lo};
		#1 md2_r = !rd_n;
		if (md2_r) conv(469);
	end
	always @(posedge sh_n) if (!cs_n && !md2_r) conv(360);
	always @(posedge rd_n) if (!cs_n) int_n <= 1'b1;
endmodule

// File: testbench/test_multistep_adc_conversion_interface.sv
`timescale 1ns/1ns
module test_multistep_adc_conversion_interface;
	logic sys_clk, rstn, start, mode, mute;
	logic [1:0] channel;
	logic [31:0] rng;
	logic [7:0] seq;
	logic [10:0] exp_q[$];
	logic [10:0] e;
	int errors, cmp_count, cyc;
	wire busy, result_valid, result_timeout, cs_n, sh_n, rd_n, chan_sel_lo, chan_sel_hi, int_n;
	wire [madc_pkg::DATA_W-1:0] result, adc_data;
	madc_host #(.FOUR_INPUT(1), .TIMEOUT(100)) dut (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.start(start),
		.mode(mode),
		.channel(channel),
		.busy(busy),
		.result_valid(result_valid),
		.result(result),
		.result_timeout(result_timeout),
		.cs_n(cs_n),
		.sh_n(sh_n),
		.rd_n(rd_n),
		.chan_sel_lo(chan_sel_lo),
		.chan_sel_hi(chan_sel_hi),
		.int_n(int_n),
		.adc_data(adc_data)
	);
	madc_adc_model adc (
		.cs_n(cs_n),
		.sh_n(sh_n),
		.rd_n(rd_n),
		.chan_sel_lo(chan_sel_lo),
		.chan_sel_hi(chan_sel_hi),
		.mute(mute),
		.int_n(int_n),
		.adc_data(adc_data)
	);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic check(input string nm, input logic [10:0] seen, input logic [10:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Second start mid-run must be ignored
	task automatic run(input logic [1:0] ch, input logic md, input logic mt);
		while (busy !== 1'b0) @(negedge sys_clk);
		@(posedge sys_clk);
		start <= 1'b1;
		mode <= md;
		channel <= ch;
		mute <= mt;
		if (!mt) seq++;
		exp_q.push_back(mt ? 11'h400 : {1'b0, ch, seq});
		@(posedge sys_clk);
		start <= 1'b0;
		@(posedge sys_clk);
		check("busy", {10'h000, busy}, 11'h001);
		check("chan_sel", {9'h000, chan_sel_hi, chan_sel_lo}, {9'h000, ch});
		repeat (2) @(posedge sys_clk);
		start <= 1'b1;
		channel <= ~ch;
		@(posedge sys_clk);
		start <= 1'b0;
		@(negedge sys_clk);
	endtask
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		mode = 1'b0;
		mute = 1'b0;
		channel = 2'h0;
		rng = 32'hbca9d959;
		seq = 8'h00;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			rng = xs(rng);
			run(i < 4 ? i[1:0] : rng[1:0], i[0], i == 5 || i == 8);
		end
		while (exp_q.size() > 0 || busy !== 1'b0) @(negedge sys_clk);
		results();
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end
	always @(posedge sys_clk) if (result_valid === 1'b1 || result_timeout === 1'b1) begin
		if (exp_q.size() == 0) check("extra", 11'h001, 11'h000);
		else begin
			e = exp_q.pop_front();
			check("timeout", {10'h000, result_timeout}, {10'h000, e[10]});
			if (!e[10]) check("result", {1'b0, result}, e);
		end
	end
endmodule
